// ### shared/tpc_defines.vh
// register map, field positions, reset values and counts of the three-phase carrier block
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

`define TPC_CNT_W 16
`define TPC_ADDR_W 8

`define TPC_OFF_CTRL 8'h08
`define TPC_OFF_CNTSTA 8'h0c
`define TPC_OFF_CNT 8'h10
`define TPC_OFF_PRD 8'h14
`define TPC_OFF_CMPU 8'h18
`define TPC_OFF_CMPV 8'h1c
`define TPC_OFF_CMPW 8'h20
`define TPC_OFF_SRCSEL 8'h24
`define TPC_OFF_OUTCTL 8'h28
`define TPC_OFF_EMGCR 8'h34
`define TPC_OFF_TRG0 8'h48
`define TPC_OFF_TRG1 8'h4c

`define TPC_CTRL_SHAPE_BIT 0
`define TPC_CTRL_INTPRD_LSB 1
`define TPC_CTRL_INTPRD_MSB 2
`define TPC_CTRL_POINT_BIT 3
`define TPC_CTRL_SHARE_BIT 4
`define TPC_CTRL_UPPER_BIT 5
`define TPC_CTRL_EXT_BIT 6
`define TPC_CTRL_W 7

`define TPC_INTPRD_HALF 2'b00
`define TPC_INTPRD_ONE 2'b01
`define TPC_INTPRD_TWO 2'b10
`define TPC_INTPRD_FOUR 2'b11

`define TPC_ESTOP_ALL_LOW 2'b00
`define TPC_ESTOP_LOWER_ON 2'b01
`define TPC_ESTOP_UPPER_ON 2'b10

`define TPC_RST_CTRL 7'h00
`define TPC_RST_PRD 16'h0000
`define TPC_RST_CMP 16'h0000
`define TPC_RST_SRCSEL 1'b0
`define TPC_RST_OUTCTL 6'h00
`define TPC_RST_EMGCR 2'h0
`define TPC_RST_TRG 16'h0000

`define TPC_CNT_ONE 16'h0001
`define TPC_EXT_DIV_LAST 2'd3

`define TPC_RESP_OKAY 2'b00
`define TPC_RESP_SLVERR 2'b10

`endif

// ### verilog/tpc_phase_cmp.v
// one phase: working compare buffer and carrier comparator
`timescale 1ns/100ps
`include "tpc_defines.vh"

module tpc_phase_cmp #(
  parameter CNT_W = `TPC_CNT_W
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire src_vec,
  input wire [CNT_W-1:0] bus_val,
  input wire [CNT_W-1:0] vec_val,
  input wire [CNT_W-1:0] cnt,
  input wire [CNT_W-1:0] share_val,
  input wire use_share,
  output reg [CNT_W-1:0] buf_r,
  output reg pwm_r
);

  wire [CNT_W-1:0] cmp_val;

  assign cmp_val = use_share ? share_val : buf_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= `TPC_RST_CMP;
      pwm_r <= 1'b0;
    end else begin
      if (load) begin
        buf_r <= src_vec ? vec_val : bus_val;
      end
      pwm_r <= (cmp_val > cnt);
    end
  end

endmodule // tpc_phase_cmp

// ### verilog/tpc_pwm_carrier.v
// three-phase pwm carrier, double-buffered compares and axi4-lite register slave
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "tpc_defines.vh"

// Operation
// - source select 0 loads working buffers from bus, 1 from vector engine.
// - compares, triggers, output control double-buffered; load only at update points.
// - sixteen-bit up/down counter, one system clock resolution.
// - mode 0 sawtooth edge-aligned, mode 1 triangular center-aligned.
// - period extension advances counter every fourth clock.
// - period comes from buffered register, refreshed once per carrier period.
// - optionally refresh period and compares every half period.
// - each phase output set by comparing its compare value with counter.
// - compare working buffers load when counter equals period value.
// - independent mode uses each phase's own compare value.
// - common mode uses U compare value for all three phases.
// - interrupt request every half (triangular carrier only), one, two or four periods.
// - control fields at bits 6,5,4,3,2-1,0, all reset to zero.
// - emergency input overrides phase outputs per emergency output mode.
// - carrier shape bit 0 sawtooth, 1 triangular.
// - duty share bit 0 common mode, 1 independent mode.
// - interrupt period 00 half, 01 one, 10 two, 11 four periods.
// - interrupt at count one or at period match; sawtooth uses period match.
module tpc_pwm_carrier #(
  parameter CNT_W = `TPC_CNT_W,
  parameter ADDR_W = `TPC_ADDR_W
) (
  input wire clk,
  input wire rst_n,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3*CNT_W-1:0] vec_cmp,
  input wire [CNT_W-1:0] vec_prd,
  input wire [CNT_W-1:0] vec_trg0,
  input wire [CNT_W-1:0] vec_trg1,
  input wire [5:0] vec_outctl,
  input wire emergency_input,
  output reg [2:0] pwm_upper_r,
  output reg [2:0] pwm_lower_r,
  output reg pwm_int_req_r,
  output reg update_pulse_r,
  output reg [CNT_W-1:0] trg0_buf_r,
  output reg [CNT_W-1:0] trg1_buf_r
);

  // first-stage registers written by the bus
  reg [`TPC_CTRL_W-1:0] ctrl_r;
  reg [CNT_W-1:0] prd_r;
  reg [3*CNT_W-1:0] cmp_r;
  reg srcsel_r;
  reg [5:0] outctl_r;
  reg [1:0] emgcr_r;
  reg [CNT_W-1:0] trg0_r;
  reg [CNT_W-1:0] trg1_r;
  // working copies
  reg [CNT_W-1:0] prd_w_r;
  reg [5:0] outctl_w_r;
  // carrier
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg dir_down_r;
  reg dir_down_nxt;
  reg [1:0] div_r;
  reg [1:0] int_cnt_r;
  reg [1:0] int_lim;
  reg emerg_s1_r;
  reg emerg_s2_r;
  // bus slave state
  reg aw_full_r;
  reg w_full_r;
  reg [ADDR_W-1:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [31:0] rd_val;
  reg rd_hit;
  reg wr_hit;

  wire shape_center = ctrl_r[`TPC_CTRL_SHAPE_BIT];
  wire [1:0] intprd = ctrl_r[`TPC_CTRL_INTPRD_MSB:`TPC_CTRL_INTPRD_LSB];
  wire point_prd = ctrl_r[`TPC_CTRL_POINT_BIT];
  wire share_indep = ctrl_r[`TPC_CTRL_SHARE_BIT];
  wire upper_only = ctrl_r[`TPC_CTRL_UPPER_BIT];
  wire period_extend = ctrl_r[`TPC_CTRL_EXT_BIT];
  wire tick;
  wire at_prd;
  wire at_one;
  wire half_upd;
  wire upd;
  wire int_event;
  wire wr_go;
  wire [31:0] wmask;
  wire [31:0] wsel;
  wire [31:0] wkeep;
  wire [3*CNT_W-1:0] cmp_buf;
  wire [2:0] phase_pwm;

  assign tick = !period_extend || (div_r == `TPC_EXT_DIV_LAST);
  // an up-count past a shorter period also wraps, else the period could never reload
  assign at_prd = tick && ((cnt_r == prd_w_r) || (!dir_down_r && (cnt_r > prd_w_r)));
  assign at_one = tick && (cnt_r == `TPC_CNT_ONE);
  assign half_upd = shape_center && (intprd == `TPC_INTPRD_HALF) && at_one;
  assign upd = at_prd || half_upd;
  assign int_event = !shape_center ? at_prd :
                     (intprd == `TPC_INTPRD_HALF) ? (at_prd || at_one) :
                     (point_prd ? at_prd : at_one);

  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wsel = wdata_r & wmask;
  assign wkeep = ~wmask;

  always @* begin
    cnt_nxt = cnt_r;
    dir_down_nxt = dir_down_r;
    if (!shape_center) begin
      dir_down_nxt = 1'b0;
      if (cnt_r >= prd_w_r) begin
        cnt_nxt = `TPC_CNT_ONE;
      end else begin
        cnt_nxt = cnt_r + `TPC_CNT_ONE;
      end
    end else if (prd_w_r <= `TPC_CNT_ONE) begin
      cnt_nxt = `TPC_CNT_ONE;
      dir_down_nxt = 1'b0;
    end else if (!dir_down_r) begin
      if (cnt_r >= prd_w_r) begin
        cnt_nxt = cnt_r - `TPC_CNT_ONE;
        dir_down_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + `TPC_CNT_ONE;
      end
    end else begin
      if (cnt_r <= `TPC_CNT_ONE) begin
        cnt_nxt = cnt_r + `TPC_CNT_ONE;
        dir_down_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - `TPC_CNT_ONE;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CNT_W{1'b0}};
      dir_down_r <= 1'b0;
      div_r <= 2'd0;
    end else begin
      div_r <= period_extend ? div_r + 2'd1 : 2'd0;
      if (tick) begin
        cnt_r <= cnt_nxt;
        dir_down_r <= dir_down_nxt;
      end
    end
  end

  // second stages load only at update
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prd_w_r <= `TPC_RST_PRD;
      outctl_w_r <= `TPC_RST_OUTCTL;
      trg0_buf_r <= `TPC_RST_TRG;
      trg1_buf_r <= `TPC_RST_TRG;
      update_pulse_r <= 1'b0;
    end else begin
      update_pulse_r <= upd;
      if (upd) begin
        prd_w_r <= srcsel_r ? vec_prd : prd_r;
        outctl_w_r <= srcsel_r ? vec_outctl : outctl_r;
        trg0_buf_r <= srcsel_r ? vec_trg0 : trg0_r;
        trg1_buf_r <= srcsel_r ? vec_trg1 : trg1_r;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
      // common mode shares the U value
      tpc_phase_cmp #(
        .CNT_W(CNT_W)
      ) u_cmp (
        .clk(clk),
        .rst_n(rst_n),
        .load(upd),
        .src_vec(srcsel_r),
        .bus_val(cmp_r[gi*CNT_W +: CNT_W]),
        .vec_val(vec_cmp[gi*CNT_W +: CNT_W]),
        .cnt(cnt_r),
        .share_val(cmp_buf[0 +: CNT_W]),
        .use_share(!share_indep),
        .buf_r(cmp_buf[gi*CNT_W +: CNT_W]),
        .pwm_r(phase_pwm[gi])
      );
    end
  endgenerate

  // interrupt every one, two or four events
  always @* begin
    case (intprd)
      `TPC_INTPRD_TWO: int_lim = 2'd1;
      `TPC_INTPRD_FOUR: int_lim = 2'd3;
      default: int_lim = 2'd0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_r <= 2'd0;
      pwm_int_req_r <= 1'b0;
    end else begin
      pwm_int_req_r <= 1'b0;
      if (int_event) begin
        if (int_cnt_r >= int_lim) begin
          int_cnt_r <= 2'd0;
          pwm_int_req_r <= 1'b1;
        end else begin
          int_cnt_r <= int_cnt_r + 2'd1;
        end
      end
    end
  end

  // phase outputs with emergency override
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emerg_s1_r <= 1'b0;
      emerg_s2_r <= 1'b0;
      pwm_upper_r <= 3'b000;
      pwm_lower_r <= 3'b000;
    end else begin
      emerg_s1_r <= emergency_input;
      emerg_s2_r <= emerg_s1_r;
      if (emerg_s2_r) begin
        pwm_upper_r <= (emgcr_r == `TPC_ESTOP_UPPER_ON) ? 3'b111 : 3'b000;
        pwm_lower_r <= (emgcr_r == `TPC_ESTOP_LOWER_ON) ? 3'b111 : 3'b000;
      end else begin
        pwm_upper_r <= phase_pwm & outctl_w_r[2:0];
        pwm_lower_r <= upper_only ? 3'b000 : (~phase_pwm & outctl_w_r[5:3]);
      end
    end
  end

  // write address decode
  always @* begin
    case (waddr_r)
      `TPC_OFF_CTRL, `TPC_OFF_CNTSTA, `TPC_OFF_CNT, `TPC_OFF_PRD,
      `TPC_OFF_CMPU, `TPC_OFF_CMPV, `TPC_OFF_CMPW, `TPC_OFF_SRCSEL,
      `TPC_OFF_OUTCTL, `TPC_OFF_EMGCR, `TPC_OFF_TRG0, `TPC_OFF_TRG1: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // axi4-lite write channel and register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPC_RESP_OKAY;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      waddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      ctrl_r <= `TPC_RST_CTRL;
      prd_r <= `TPC_RST_PRD;
      cmp_r <= {3{`TPC_RST_CMP}};
      srcsel_r <= `TPC_RST_SRCSEL;
      outctl_r <= `TPC_RST_OUTCTL;
      emgcr_r <= `TPC_RST_EMGCR;
      trg0_r <= `TPC_RST_TRG;
      trg1_r <= `TPC_RST_TRG;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_r && !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full_r && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        waddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
        // software writes first stages ahead of update
        case (waddr_r)
          `TPC_OFF_CTRL: ctrl_r <= (ctrl_r & wkeep[`TPC_CTRL_W-1:0]) | wsel[`TPC_CTRL_W-1:0];
          `TPC_OFF_PRD: prd_r <= (prd_r & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          `TPC_OFF_CMPU: cmp_r[0 +: CNT_W] <= (cmp_r[0 +: CNT_W] & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          `TPC_OFF_CMPV: cmp_r[CNT_W +: CNT_W] <= (cmp_r[CNT_W +: CNT_W] & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          `TPC_OFF_CMPW: cmp_r[2*CNT_W +: CNT_W] <= (cmp_r[2*CNT_W +: CNT_W] & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          `TPC_OFF_SRCSEL: srcsel_r <= wstrb_r[0] ? wdata_r[0] : srcsel_r;
          `TPC_OFF_OUTCTL: outctl_r <= wstrb_r[0] ? wdata_r[5:0] : outctl_r;
          `TPC_OFF_EMGCR: emgcr_r <= wstrb_r[0] ? wdata_r[1:0] : emgcr_r;
          `TPC_OFF_TRG0: trg0_r <= (trg0_r & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          `TPC_OFF_TRG1: trg1_r <= (trg1_r & wkeep[CNT_W-1:0]) | wsel[CNT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // read decode
  always @* begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      `TPC_OFF_CTRL: rd_val = {25'h0, ctrl_r};
      `TPC_OFF_CNTSTA: rd_val = {31'h0, dir_down_r};
      `TPC_OFF_CNT: rd_val = {16'h0, cnt_r};
      `TPC_OFF_PRD: rd_val = {16'h0, prd_r};
      `TPC_OFF_CMPU: rd_val = {16'h0, cmp_r[0 +: CNT_W]};
      `TPC_OFF_CMPV: rd_val = {16'h0, cmp_r[CNT_W +: CNT_W]};
      `TPC_OFF_CMPW: rd_val = {16'h0, cmp_r[2*CNT_W +: CNT_W]};
      `TPC_OFF_SRCSEL: rd_val = {31'h0, srcsel_r};
      `TPC_OFF_OUTCTL: rd_val = {26'h0, outctl_r};
      `TPC_OFF_EMGCR: rd_val = {30'h0, emgcr_r};
      `TPC_OFF_TRG0: rd_val = {16'h0, trg0_r};
      `TPC_OFF_TRG1: rd_val = {16'h0, trg1_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // axi4-lite read channel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TPC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // tpc_pwm_carrier

// ### dv/tpc_pwm_carrier_props.sv
// concurrent checks on the ports of the three-phase carrier block
`timescale 1ns/100ps
module tpc_pwm_carrier_props #(
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_arvalid,
  input wire s_axi_rready,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire emergency_input,
  input wire [2:0] pwm_upper_r,
  input wire [2:0] pwm_lower_r,
  input wire pwm_int_req_r,
  input wire update_pulse_r,
  input wire [CNT_W-1:0] trg0_buf_r,
  input wire [CNT_W-1:0] trg1_buf_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_trg0_at_update;
    $changed(trg0_buf_r) |-> ##[0:1] update_pulse_r;
  endproperty
  a_trg0_at_update: assert property (p_trg0_at_update) else $error("trigger 0 buffer moved off update");

  property p_trg1_at_update;
    $changed(trg1_buf_r) |-> ##[0:1] update_pulse_r;
  endproperty
  a_trg1_at_update: assert property (p_trg1_at_update) else $error("trigger 1 buffer moved off update");

  property p_no_shoot;
    (pwm_upper_r & pwm_lower_r) == 3'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("upper and lower of one phase both on");

  property p_emerg_override;
    emergency_input [*5] |-> (pwm_upper_r == 3'h0 || pwm_lower_r == 3'h0)
      && (pwm_upper_r == 3'h0 || pwm_upper_r == 3'h7) && (pwm_lower_r == 3'h0 || pwm_lower_r == 3'h7);
  endproperty
  a_emerg_override: assert property (p_emerg_override) else $error("outputs not overridden by emergency");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");

  property p_wr_answer;
    $rose(s_axi_awvalid) && $rose(s_axi_wvalid) |-> ##[2:4] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");

  property p_rd_answer;
    $rose(s_axi_arvalid) |-> ##[1:3] s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");

  c_int: cover property (pwm_int_req_r);
  c_upd: cover property (update_pulse_r);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // tpc_pwm_carrier_props

bind tpc_pwm_carrier tpc_pwm_carrier_props #(.CNT_W(CNT_W)) props_u (.*);

// ### dv/tpc_ve_model.sv
// vector engine stand-in feeding compare, period, trigger and output values
`timescale 1ns/100ps
module tpc_vec_model (
  input wire clk,
  input wire rst_n,
  input wire [15:0] base_val,
  output reg [47:0] vec_cmp,
  output reg [15:0] vec_prd,
  output reg [15:0] vec_trg0,
  output reg [15:0] vec_trg1,
  output reg [5:0] vec_outctl
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_cmp <= 48'h0;
      vec_prd <= 16'h0;
      vec_trg0 <= 16'h0;
      vec_trg1 <= 16'h0;
      vec_outctl <= 6'h0;
    end else begin
      vec_cmp <= {base_val + 16'h2, base_val + 16'h1, base_val};
      vec_prd <= base_val + 16'h3;
      vec_trg0 <= ~base_val;
      vec_trg1 <= base_val ^ 16'h00f0;
      vec_outctl <= 6'h3f;
    end
  end
endmodule // tpc_vec_model

// ### dv/tb_tpc_pwm_carrier.sv
// register-level testbench of the three-phase carrier block
`timescale 1ns/100ps
`include "tpc_defines.vh"
module tb_tpc_pwm_carrier;
  reg clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, emergency_input;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd;
  reg [3:0] s_axi_wstrb;
  reg [15:0] base_val;
  reg [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_int_req_r, update_pulse_r;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [47:0] vec_cmp;
  wire [15:0] vec_prd, vec_trg0, vec_trg1, trg0_buf_r, trg1_buf_r;
  wire [5:0] vec_outctl;
  wire [2:0] pwm_upper_r, pwm_lower_r;
  integer num_errors, tests_run, cycles, n_u, n_v, n_w, n_x, n_i, i;

  tpc_pwm_carrier dut_u (.*);
  tpc_vec_model vec_u (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer k;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      rsp = 2'b11;
      for (k = 0; k < 64 && rsp === 2'b11; k = k + 1) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        // bready comes one cycle after bvalid so the response must hold
        if (s_axi_bvalid && s_axi_bready) begin
          rsp = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end else if (s_axi_bvalid) begin
          s_axi_bready <= 1'b1;
        end
      end
      chk(rsp, er);
    end
  endtask

  task rd_chk(input [7:0] a, input [31:0] exp, input [1:0] er);
    integer k;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      rsp = 2'b11;
      for (k = 0; k < 64 && rsp === 2'b11; k = k + 1) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        // rready comes one cycle after rvalid so the data must hold
        if (s_axi_rvalid && s_axi_rready) begin
          rsp = s_axi_rresp;
          rd = s_axi_rdata;
          s_axi_rready <= 1'b0;
        end else if (s_axi_rvalid) begin
          s_axi_rready <= 1'b1;
        end
      end
      chk(rsp, er);
      chk(rd, exp);
    end
  endtask

  // waits for a buffer update, then counts high samples over 64 clocks
  task win;
    integer k;
    begin
      for (k = 0; k < 300 && update_pulse_r !== 1'b1; k = k + 1) @(negedge clk);
      repeat (4) @(negedge clk);
      {n_u, n_v, n_w, n_x, n_i} = 0;
      for (k = 0; k < 64; k = k + 1) begin
        @(negedge clk);
        n_u = n_u + pwm_upper_r[0];
        n_v = n_v + pwm_upper_r[1];
        n_w = n_w + pwm_upper_r[2];
        n_x = n_x + pwm_lower_r[0];
        n_i = n_i + pwm_int_req_r;
      end
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, emergency_input} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    base_val = 16'h0005;
    {num_errors, tests_run, cycles} = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`TPC_OFF_CTRL, 32'h0, `TPC_RESP_OKAY);
    rd_chk(`TPC_OFF_SRCSEL, 32'h0, `TPC_RESP_OKAY);
    rd_chk(8'h70, 32'h0, `TPC_RESP_SLVERR);
    wr(8'h70, 32'h1234, `TPC_RESP_SLVERR);
    for (i = 0; i < 7; i = i + 1) begin
      wr(`TPC_OFF_CTRL, 32'h1 << i, `TPC_RESP_OKAY);
      rd_chk(`TPC_OFF_CTRL, 32'h1 << i, `TPC_RESP_OKAY);
    end
    wr(`TPC_OFF_CTRL, 32'hffffffff, `TPC_RESP_OKAY);
    rd_chk(`TPC_OFF_CTRL, 32'h7f, `TPC_RESP_OKAY);
    $display("test registers done");
    wr(`TPC_OFF_PRD, 32'h8, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CMPU, 32'h4, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CMPV, 32'h0, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CMPW, 32'h9, `TPC_RESP_OKAY);
    wr(`TPC_OFF_OUTCTL, 32'h3f, `TPC_RESP_OKAY);
    wr(`TPC_OFF_TRG0, 32'h0abc, `TPC_RESP_OKAY);
    wr(`TPC_OFF_TRG1, 32'h0123, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CTRL, 32'h01, `TPC_RESP_OKAY);
    win;
    chk(trg0_buf_r, 32'h0abc);
    chk(trg1_buf_r, 32'h0123);
    wr(`TPC_OFF_CTRL, 32'h12, `TPC_RESP_OKAY);
    win;
    chk(n_u, 24);
    chk(n_v, 0);
    chk(n_w, 64);
    chk(n_x, 40);
    rd_chk(`TPC_OFF_CNTSTA, 32'h0, `TPC_RESP_OKAY);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`TPC_OFF_CTRL, 32'h10 | (i << 1), `TPC_RESP_OKAY);
      win;
      chk(n_i, (i < 2) ? 8 : ((i == 2) ? 4 : 2));
    end
    wr(`TPC_OFF_CTRL, 32'h02, `TPC_RESP_OKAY);
    win;
    chk(n_v, 24);
    chk(n_w, 24);
    wr(`TPC_OFF_CTRL, 32'h52, `TPC_RESP_OKAY);
    win;
    chk(n_u, 24);
    chk(n_i, 2);
    wr(`TPC_OFF_PRD, 32'h9, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CTRL, 32'h3b, `TPC_RESP_OKAY);
    win;
    chk(n_u, 20);
    chk(n_w, 60);
    chk(n_x, 0);
    chk(n_i, 4);
    wr(`TPC_OFF_CTRL, 32'h33, `TPC_RESP_OKAY);
    win;
    chk(n_i, 4);
    wr(`TPC_OFF_CTRL, 32'h31, `TPC_RESP_OKAY);
    win;
    chk(n_i, 8);
    $display("test carrier done");
    wr(`TPC_OFF_SRCSEL, 32'h1, `TPC_RESP_OKAY);
    wr(`TPC_OFF_CTRL, 32'h12, `TPC_RESP_OKAY);
    win;
    chk(n_u, 32);
    chk(n_v, 40);
    chk(n_w, 48);
    chk(trg0_buf_r, 32'hfffa);
    chk(trg1_buf_r, 32'h00f5);
    wr(`TPC_OFF_SRCSEL, 32'h0, `TPC_RESP_OKAY);
    win;
    chk(trg0_buf_r, 32'h0abc);
    $display("test source select done");
    wr(`TPC_OFF_EMGCR, 32'h1, `TPC_RESP_OKAY);
    emergency_input <= 1'b1;
    repeat (6) @(negedge clk);
    chk({pwm_upper_r, pwm_lower_r}, 6'h07);
    wr(`TPC_OFF_EMGCR, 32'h2, `TPC_RESP_OKAY);
    repeat (3) @(negedge clk);
    chk({pwm_upper_r, pwm_lower_r}, 6'h38);
    wr(`TPC_OFF_EMGCR, 32'h0, `TPC_RESP_OKAY);
    repeat (3) @(negedge clk);
    chk({pwm_upper_r, pwm_lower_r}, 6'h00);
    @(posedge clk);
    emergency_input <= 1'b0;
    $display("test emergency done");
    print_verdict;
  end
endmodule // tb_tpc_pwm_carrier
